// *** design/adc_readout_defs.vh ***
`ifndef ADC_READOUT_DEFS_VH
`define ADC_READOUT_DEFS_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define MCLK_MHZ 32'h0000_00FA
`define T_CONV_US 32'h0000_40D8
`define T_CONV_MAX_US 32'h0000_59D8
`define T_POR_US 32'h0000_01F4
`define CONV_CYCLES (`T_CONV_US * `MCLK_MHZ)
`define POR_CYCLES (`T_POR_US * `MCLK_MHZ)
`define CNT_W 23

// ==========================================================================
// Result format
// ==========================================================================
`define RES_W 16
`define SAMP_W 18
`define FIFO_DEPTH 32
`define BITS_PER_WORD 5'h10
`define BIT_CNT_W 5
`define CODE_MID 18'h0_8000
`define CODE_LIM 18'h0_8000
`define CODE_MAX 16'hFFFF
`define CODE_MIN 16'h0000

`endif

// *** design/sample_fifo.v ***
// ==========================================================================
// Sample buffer
// ==========================================================================
// A first-in first-out store whose read word always comes from a register.
// It holds DEPTH words in the array plus one in the output register.
module sample_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  reg [WIDTH-1:0] out_data_q;
  reg out_valid_q;
  wire push;
  wire pop;
  wire [AW:0] depth_w;
  localparam [31:0] DEPTH32 = DEPTH;

  assign depth_w = DEPTH32[AW:0];
  assign in_ready = (count_q != depth_w);
  assign push = in_valid & in_ready;
  // The array is drained into the output register when it is empty or taken.
  assign pop = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_data_q <= {WIDTH{1'b0}};
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data_q <= mem[rd_ptr_q];
        out_valid_q <= 1'b1;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// *** design/adc_readout.v ***
// How it works
// - Code is 32768 times ratio plus 32768.
// - Code clamps at 65535 and at 0.
// - Result leaves MSB first, sign bit leading.
// - Each result from latest conversion only.
// - Top bit appears once select and clock are both low.
// - Next bit follows each serial clock fall.
// - Status: high converting, low when asleep.
// - Conversion time fixed near 16.6 ms.
// - Works with clock idling high or low.
// - After 16 bits, select rise or clock fall restarts.
// - Select rise during output aborts, restarts.
// - Status monitor only with clock idling high.
// - Sleep entered alone after conversion.
// - Idle low: sixteenth fall starts conversion.
// - Leave sleep only when select, clock low.
// - Nothing on the link aborts a conversion.
// - Power-on reset clears, then converts.
// - Data pin driven only while select low.
`include "adc_readout_defs.vh"

// ==========================================================================
// Converter control and serial readout
// ==========================================================================
module adc_readout #(
  parameter [31:0] CONV_CYCLES = `CONV_CYCLES,
  parameter [31:0] POR_CYCLES = `POR_CYCLES,
  parameter CNT_W = `CNT_W,
  parameter SAMP_W = `SAMP_W,
  parameter FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire mclk,
  input wire reset,
  input wire cs_n,
  input wire sck,
  output wire sdo,
  output wire sdo_oe,
  input wire samp_valid,
  output wire samp_ready,
  input wire [SAMP_W-1:0] samp_data,
  output wire converting,
  output wire conv_done,
  output wire [`RES_W-1:0] result
);

  // ========================================================================
  // States
  // ========================================================================
  localparam [3:0] ST_POR = 4'h1;
  localparam [3:0] ST_CONV = 4'h2;
  localparam [3:0] ST_SLEEP = 4'h4;
  localparam [3:0] ST_DOUT = 4'h8;

  localparam [31:0] CONV_END32 = CONV_CYCLES - 32'h0000_0001;
  localparam [31:0] POR_END32 = POR_CYCLES - 32'h0000_0001;
  localparam [CNT_W-1:0] CONV_END = CONV_END32[CNT_W-1:0];
  localparam [CNT_W-1:0] POR_END = POR_END32[CNT_W-1:0];
  localparam [`BIT_CNT_W-1:0] LAST_BIT = `BITS_PER_WORD - 1'b1;

  // ========================================================================
  // Code mapping
  // ========================================================================
  // The front end delivers the signed ratio of input to reference, scaled
  // so that a ratio of one reads as 32768. Offsetting by mid-scale gives a
  // straight binary code whose top bit is set for a non-negative input.
  function [`RES_W-1:0] code_of;
    input [SAMP_W-1:0] ratio;
    reg [SAMP_W-1:0] sum;
    begin
      sum = ratio + `CODE_MID;
      if (!ratio[SAMP_W-1] && (ratio >= `CODE_LIM)) begin
        code_of = `CODE_MAX;
      end else if (ratio[SAMP_W-1] && ((~ratio + 1'b1) >= `CODE_LIM)) begin
        code_of = `CODE_MIN;
      end else begin
        code_of = sum[`RES_W-1:0];
      end
    end
  endfunction

  // ========================================================================
  // Buffer sizing
  // ========================================================================
  // Address bits for a buffer of the given depth, never fewer than one.
  // The buffer depth may then be changed without touching the address width.
  function integer addr_bits;
    input integer depth;
    integer n;
    begin
      n = 1;
      while ((32'h0000_0001 << n) < depth) begin
        n = n + 1;
      end
      addr_bits = n;
    end
  endfunction

  localparam FIFO_AW = addr_bits(FIFO_DEPTH);

  // ========================================================================
  // Pin synchronisers and edge detection
  // ========================================================================
  // Both pins pass two flops before any logic reads them; the third flop
  // only remembers the last synchronised level so that edges can be found.
  // The flops reset to an idle select and an idle-low clock, so no false
  // select rise or clock fall follows reset.
  reg cs_meta_q;
  reg cs_sync_q;
  reg cs_last_q;
  reg sck_meta_q;
  reg sck_sync_q;
  reg sck_last_q;
  wire cs_rise;
  wire sck_fall;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_last_q <= 1'b1;
      sck_meta_q <= 1'b0;
      sck_sync_q <= 1'b0;
      sck_last_q <= 1'b0;
    end else begin
      cs_meta_q <= cs_n;
      cs_sync_q <= cs_meta_q;
      cs_last_q <= cs_sync_q;
      sck_meta_q <= sck;
      sck_sync_q <= sck_meta_q;
      sck_last_q <= sck_sync_q;
    end
  end

  assign cs_rise = cs_sync_q & ~cs_last_q;
  assign sck_fall = sck_last_q & ~sck_sync_q;

  // ========================================================================
  // Sample buffer
  // ========================================================================
  wire buf_valid;
  wire buf_ready;
  wire [SAMP_W-1:0] buf_data;

  sample_fifo #(
    .WIDTH(SAMP_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_valid(samp_valid),
    .in_ready(samp_ready),
    .in_data(samp_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // ========================================================================
  // Sequencer
  // ========================================================================
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;
  reg [`BIT_CNT_W-1:0] bits_q;
  reg [`BIT_CNT_W-1:0] bits_d;
  reg [`RES_W-1:0] shift_q;
  reg [`RES_W-1:0] shift_d;
  reg [`RES_W-1:0] result_q;
  reg [`RES_W-1:0] result_d;
  reg [SAMP_W-1:0] last_q;
  reg [SAMP_W-1:0] last_d;
  reg done_q;
  reg done_d;
  reg sdo_q;
  reg sdo_d;
  reg oe_q;
  wire conv_end;
  wire por_end;
  wire in_conv;

  // Samples are taken from the buffer only while converting, so the buffer
  // fills during sleep and readout and stalls the source through its ready.
  assign in_conv = (state_q == ST_CONV);
  assign buf_ready = in_conv;
  assign conv_end = (cnt_q == CONV_END);
  assign por_end = (cnt_q == POR_END);

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    bits_d = bits_q;
    shift_d = shift_q;
    result_d = result_q;
    last_d = last_q;
    done_d = 1'b0;
    case (state_q)
      ST_POR: begin
        cnt_d = cnt_q + 1'b1;
        if (por_end) begin
          state_d = ST_CONV;
          cnt_d = {CNT_W{1'b0}};
        end
      end
      ST_CONV: begin
        // Link activity is ignored here; only conv_end or the reset ends a conversion.
        cnt_d = cnt_q + 1'b1;
        if (buf_valid) begin
          last_d = buf_data;
        end
        if (conv_end) begin
          // The result is taken once per conversion and held until the
          // next one completes.
          result_d = code_of(last_d);
          done_d = 1'b1;
          state_d = ST_SLEEP;
          cnt_d = {CNT_W{1'b0}};
        end
      end
      ST_SLEEP: begin
        // The fall that brings an idle-high host into readout is not
        // counted, so such a host restarts with a seventeenth pulse.
        if (~cs_sync_q & ~sck_sync_q) begin
          state_d = ST_DOUT;
          shift_d = result_q;
          bits_d = {`BIT_CNT_W{1'b0}};
        end
      end
      ST_DOUT: begin
        // A select rise always restarts, while a clock fall in the same cycle restarts
        // only when it is the sixteenth, so the rise is simply given priority.
        if (cs_rise) begin
          state_d = ST_CONV;
          cnt_d = {CNT_W{1'b0}};
        end else if (sck_fall) begin
          shift_d = {shift_q[`RES_W-2:0], 1'b0};
          bits_d = bits_q + 1'b1;
          if (bits_q == LAST_BIT) begin
            state_d = ST_CONV;
            cnt_d = {CNT_W{1'b0}};
          end
        end
      end
      default: begin
        state_d = ST_POR;
        cnt_d = {CNT_W{1'b0}};
      end
    endcase
  end

  // ========================================================================
  // Serial data pin
  // ========================================================================
  // Outside readout the pin reports status: high while the power-on wait or
  // a conversion runs, low once asleep. The status is only meaningful to a
  // host that idles the clock high, since a low clock leaves sleep at once.
  always @* begin
    if (state_d == ST_DOUT) begin
      sdo_d = shift_d[`RES_W-1];
    end else if (state_d == ST_SLEEP) begin
      sdo_d = 1'b0;
    end else begin
      sdo_d = 1'b1;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_POR;
      cnt_q <= {CNT_W{1'b0}};
      bits_q <= {`BIT_CNT_W{1'b0}};
      shift_q <= {`RES_W{1'b0}};
      result_q <= {`RES_W{1'b0}};
      last_q <= {SAMP_W{1'b0}};
      done_q <= 1'b0;
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      result_q <= result_d;
      last_q <= last_d;
      done_q <= done_d;
      sdo_q <= sdo_d;
      oe_q <= ~cs_sync_q;
    end
  end

  assign sdo = sdo_q;
  assign sdo_oe = oe_q;
  assign converting = in_conv;
  assign conv_done = done_q;
  assign result = result_q;

endmodule

// *** tb/adc_readout_monitor.sv ***
module adc_readout_monitor #(
  parameter [31:0] CONV_CYCLES = 32'h0000_00C8
) (
  input wire mclk,
  input wire reset,
  input wire cs_n,
  input wire sck,
  input wire sdo,
  input wire sdo_oe,
  input wire converting,
  input wire conv_done,
  input wire [15:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ========
  // Counts the cycles of the running conversion.
  assign cnt_d = converting ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
  always @(posedge mclk or posedge reset) begin
    if (reset)
      cnt_q <= 32'h0000_0000;
    else
      cnt_q <= cnt_d;
  end
  sequence s_entry;
    $fell(cs_n) && !sck && !converting
      ##1 (!cs_n && !sck && !converting) [*3];
  endsequence
  sequence s_sel;
    (!cs_n) [*4];
  endsequence
  a_oe_on: assert property (s_sel |-> sdo_oe)
    else $error("sdo not driven while selected");
  a_oe_off: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  a_first_bit: assert property (s_entry |=> sdo == result[15])
    else $error("first bit is not the result msb");
  a_conv_length: assert property (conv_done |->
    cnt_q >= CONV_CYCLES - 2 && cnt_q <= CONV_CYCLES + 2)
    else $error("conversion length wrong");
  a_no_abort: assert property (
    converting && cnt_q < CONV_CYCLES - 3 |=> converting)
    else $error("conversion cut short");
  a_sleep_alone: assert property (conv_done |=> (!converting) [*8])
    else $error("no sleep after conversion");
  a_result_hold: assert property ($changed(result) |-> conv_done)
    else $error("result changed without a conversion");
  a_busy_high: assert property (
    converting && $past(converting) && sdo_oe |-> sdo)
    else $error("status low while converting");
  a_done_low: assert property (conv_done && sdo_oe |-> !sdo)
    else $error("status high after conversion");
endmodule

bind adc_readout adc_readout_monitor #(.CONV_CYCLES(CONV_CYCLES)) mon (
  .mclk(mclk),
  .reset(reset),
  .cs_n(cs_n),
  .sck(sck),
  .sdo(sdo),
  .sdo_oe(sdo_oe),
  .converting(converting),
  .conv_done(conv_done),
  .result(result)
);

// *** tb/serial_host.sv ***
module serial_host (
  output logic cs_n,
  output logic sck,
  input wire sdo,
  input wire sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  wire line;
  // ========
  // A released line shows the inverse of its last driven level.
  always @* begin
    if (sdo_oe)
      last = sdo;
  end
  assign line = sdo_oe ? sdo : !last;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  task xfer(input bit cpol, input int n, input bit fall_end,
    output logic [15:0] w);
    w = 16'h0000;
    sck = cpol;
    #20;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      #20;
      sck = 1'b1;
      if (i < 16)
        w = {w[14:0], line};
      #12;
    end
    if (fall_end) begin
      sck = 1'b0;
      #20;
    end
    cs_n = 1'b1;
    #20;
    sck = cpol;
    #20;
  endtask
  task status_on(output logic b);
    sck = 1'b1;
    #20;
    cs_n = 1'b0;
    #40;
    b = line;
  endtask
  task status_off();
    cs_n = 1'b1;
    #20;
  endtask
endmodule

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic samp_valid = 1'b0;
  logic [17:0] samp_data = 18'h0_0000;
  wire cs_n, sck, sdo, sdo_oe, samp_ready, converting, conv_done;
  wire [15:0] result;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] qexp [$];
  logic [15:0] rnd = 16'h903A;
  logic [17:0] tbl [4] = '{18'h0_7FFF, 18'h0_8000, 18'h3_8000, 18'h0_0000};
  always #2 mclk = ~mclk;
  adc_readout #(
    .CONV_CYCLES(32'h0000_00C8),
    .POR_CYCLES(32'h0000_0014)
  ) DUT (
    .mclk(mclk),
    .reset(reset),
    .cs_n(cs_n),
    .sck(sck),
    .sdo(sdo),
    .sdo_oe(sdo_oe),
    .samp_valid(samp_valid),
    .samp_ready(samp_ready),
    .samp_data(samp_data),
    .converting(converting),
    .conv_done(conv_done),
    .result(result)
  );
  serial_host host (.cs_n(cs_n), .sck(sck), .sdo(sdo), .sdo_oe(sdo_oe));
  // ========
  function logic [15:0] code_of(input logic [17:0] r);
    int v;
    v = $signed(r) + 32768;
    if (v > 65535)
      v = 65535;
    if (v < 0)
      v = 0;
    return v[15:0];
  endfunction
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task push(input logic [17:0] d, output bit ok);
    @(posedge mclk);
    #1;
    samp_valid = 1'b1;
    samp_data = d;
    ok = samp_ready;
    @(posedge mclk);
    #1;
    samp_valid = 1'b0;
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Each finished conversion is compared with the oldest expected code.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end else if (conv_done === 1'b1) begin
      check(result, qexp.size() ? qexp.pop_front() : 16'hxxxx);
    end
  end
  initial begin
    logic [17:0] s;
    logic [15:0] prev, w, n_ok, last;
    bit ok;
    logic b;
    repeat (2) @(posedge mclk);
    #1;
    reset = 1'b0;
    s = 18'h3_0000;
    push(s, ok);
    qexp.push_back(code_of(s));
    prev = code_of(s);
    do @(posedge mclk); while (conv_done !== 1'b1);
    for (int m = 0; m < 6; m++) begin
      n_ok = 16'h0000;
      for (int i = 0; i < (m == 5 ? 40 : 1); i++) begin
        rnd = lfsr(rnd);
        s = m < 4 ? tbl[m] : {rnd[1:0], rnd};
        push(s, ok);
        if (ok) begin
          n_ok++;
          last = code_of(s);
        end
      end
      if (m == 5)
        check(n_ok, 16'h0021);
      qexp.push_back(last);
      host.xfer(m == 2 || m == 3, m == 3 ? 17 : (m == 4 ? 4 : 16),
        m == 1 || m == 5, w);
      if (m == 4)
        check(w, prev >> 12);
      else
        check(w, prev);
      prev = last;
      host.status_on(b);
      check({15'h0000, b}, 16'h0001);
      do @(posedge mclk); while (conv_done !== 1'b1);
      #1;
      check({15'h0000, host.line}, 16'h0000);
      host.status_off();
      $display("test %0d done", m);
    end
    final_report();
  end
endmodule
